// ---- rtl/ots_map.svh ----
// Function codes, terminal indices and reset values for the output terminal selector
`ifndef OTS_MAP_SVH
`define OTS_MAP_SVH

// Function code space
`define OTS_NUM_FUNCS      100
`define OTS_POS_LAST       8'h63
`define OTS_NEG_FIRST      8'h64
`define OTS_NEG_LAST       8'hC7
`define OTS_NEG_OFFSET     8'h64

// Individual function codes, positive form
`define OTS_F_MAINS1       7'h47
`define OTS_F_DRIVE1       7'h4B
`define OTS_F_PUMP_FIRST   7'h47
`define OTS_F_PUMP_LAST    7'h4E
`define OTS_F_ENERGY_PULSE 7'h4F
`define OTS_F_DC_FEED      7'h55
`define OTS_F_LIFE         7'h5A
`define OTS_F_PWR_OFF      7'h5B
`define OTS_F_AVG_TOGGLE   7'h5C
`define OTS_F_CUR_AVG      7'h5D
`define OTS_F_FAULT2       7'h5E
`define OTS_F_HOST_SET     7'h60
`define OTS_F_LIGHT        7'h62
`define OTS_F_FAULT        7'h63

// Fault code option value that reroutes the status terminals
`define OTS_FCODE_ON       8'h01

// Terminal indices
`define OTS_T_RUN          0
`define OTS_T_AT_SPEED     1
`define OTS_T_PWR_FAIL     2
`define OTS_T_OVERLOAD     3
`define OTS_T_FREQ_DET     4
`define OTS_T_RELAY1       5
`define OTS_T_RELAY2       6
`define OTS_NUM_TERMS      7
`define OTS_FIRST_RELAY    5

// Reset values
`define OTS_TERM_RST       1'b0
`define OTS_FLAG_RST       1'b0

`endif

// ---- rtl/ots_pkg.sv ----
// Types shared by the output terminal selector
package ots_pkg;

   typedef logic [7:0] ots_code_t;

   typedef struct packed {
      logic trip;
      logic internal_cause;
      logic inv_reset;
      logic power_off;
   } ots_fault_in_s;

   typedef struct packed {
      logic [3:0] mains;
      logic [3:0] drive;
   } ots_pump_s;

   typedef struct packed {
      logic       ac_power_fail;
      logic       ac_undervoltage;
      logic [3:0] life_worn;
      logic       fan_fail;
      logic       comm_warn;
   } ots_health_s;

   typedef struct packed {
      logic       valid;
      logic       neg;
      logic [6:0] idx;
   } ots_dec_s;

endpackage

// ---- rtl/ots_terminal.sv ----
// One output terminal: decodes its selection code and registers the chosen source
`timescale 1ns/1ps
`default_nettype none
`include "ots_map.svh"

module ots_terminal #(
   parameter bit IS_RELAY = 1'b0
) (
   input  wire  logic                        mclk,
   input  wire  logic                        rst,
   input  wire  ots_pkg::ots_code_t          sel_code,
   input  wire  logic [`OTS_NUM_FUNCS-1:0]   src,
   input  wire  logic                        host_bit,
   input  wire  logic                        override_en,
   input  wire  logic                        override_val,
   output logic                              term_on
);

   function automatic ots_pkg::ots_dec_s decode(input ots_pkg::ots_code_t code, input logic relay);
      ots_pkg::ots_dec_s d;
      ots_pkg::ots_code_t off;
      d   = '0;
      off = code - `OTS_NEG_OFFSET;
      if (code <= `OTS_POS_LAST) begin
         d.valid = 1'b1;
         d.idx   = code[6:0];
      end else if (code <= `OTS_NEG_LAST) begin
         d.valid = 1'b1;
         d.neg   = 1'b1; // RL1
         d.idx   = off[6:0];
      end
      // Pump contacts have no inverted form
      if (d.neg && d.idx >= `OTS_F_PUMP_FIRST && d.idx <= `OTS_F_PUMP_LAST)
         d.valid = 1'b0; // RL14
      // Fast-toggling monitors are refused on relays
      if (relay && (d.idx == `OTS_F_AVG_TOGGLE || d.idx == `OTS_F_CUR_AVG))
         d.valid = 1'b0; // RL6 RL7
      return d;
   endfunction

   ots_pkg::ots_dec_s dec;
   logic              level;
   logic              on_next;

   always_comb begin
      dec     = decode(sel_code, IS_RELAY);
      level   = (dec.idx == `OTS_F_HOST_SET) ? host_bit : src[dec.idx]; // RL13
      on_next = dec.valid & (level ^ dec.neg); // RL1
      if (override_en)
         on_next = override_val; // RL15
   end

   always_ff @(posedge mclk) begin
      if (rst)
         term_on <= `OTS_TERM_RST;
      else
         term_on <= on_next; // RL18
   end

endmodule
`default_nettype wire

// ---- rtl/ots_top.sv ----
// Output terminal function selector: builds status sources and drives every terminal
//
// Function
// RL1 - Codes 0..99 conduct while active; 100..199 stop conducting while active.
// RL2 - One function code may drive several terminals, each independently.
// RL3 - Secondary fault sets on trip, holds through reset, clears after release.
// RL4 - Primary fault sets on trip and clears as soon as fault reset.
// RL5 - Supply removal drops the secondary fault output at once.
// RL6 - Average-update output toggles per update; refused on relay terminals.
// RL7 - Current-average pulse output is refused on relay terminals.
// RL8 - Energy pulse emitted each time accumulated energy reaches the increment.
// RL9 - DC feeding output active during AC power failure or undervoltage.
// RL10 - Life alarm active when any monitored part nears end of life.
// RL11 - Power-off fault sets on trip from internal failure or miswiring.
// RL12 - Light alarm active during fan failure or communication warning.
// RL13 - Host-set output follows written value, independent of drive state.
// RL14 - Pump-staging contact codes selectable in positive polarity only.
// RL15 - Fault-code option one reroutes four status terminals to fault code.
// RL16 - Running terminal and fault relays ignore the fault-code option.
// RL17 - Installer avoids frequently toggling functions on the two relays.
// RL18 - Each terminal registered from selected source within one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ots_map.svh"

module ots_top #(
   parameter int NUM_TERMS   = `OTS_NUM_TERMS,
   parameter int FIRST_RELAY = `OTS_FIRST_RELAY,
   parameter int ENERGY_W    = 16
) (
   input  wire  logic                         mclk,
   input  wire  logic                         rst,

   // Terminal configuration
   input  wire  ots_pkg::ots_code_t [NUM_TERMS-1:0] sel_code,
   input  wire  ots_pkg::ots_code_t                 fault_code_option,
   input  wire  logic [NUM_TERMS-1:0]               host_set_output,

   // Status computed elsewhere in the drive, indexed by function code
   input  wire  logic [`OTS_NUM_FUNCS-1:0]          gen_status,

   // Fault events and inverter reset
   input  wire  ots_pkg::ots_fault_in_s             fault_in,
   input  wire  logic [3:0]                         fault_code,

   // Supply and component health
   input  wire  ots_pkg::ots_health_s               health,

   // Pump staging contacts
   input  wire  ots_pkg::ots_pump_s                 pump,

   // Energy monitor
   input  wire  logic                               energy_valid,
   input  wire  logic [ENERGY_W-1:0]                energy_inc,
   input  wire  logic [ENERGY_W-1:0]                energy_step,
   input  wire  logic                               energy_avg_update,
   input  wire  logic                               current_avg_pulse_in,

   // Terminals
   output logic [NUM_TERMS-1:0]                     terminal_on,

   // Internal status, for the operation panel and monitors
   output logic                                     primary_fault_out,
   output logic                                     secondary_fault_out,
   output logic                                     power_off_fault_out,
   output logic                                     energy_pulse_out,
   output logic                                     energy_avg_toggle_out,
   output logic                                     dc_feeding_out,
   output logic                                     life_alarm_out,
   output logic                                     light_alarm_out,
   output logic                                     current_avg_pulse_out,
   output logic                                     fault_code_active
);

   // ------------------------------------------------------------------
   // Fault flags
   // ------------------------------------------------------------------
   logic primary_fault_reg;
   logic secondary_fault_reg;
   logic power_off_fault_reg;
   logic inv_reset_reg;
   logic inv_reset_release;

   // Falling edge of the inverter reset marks its release
   assign inv_reset_release = inv_reset_reg & ~fault_in.inv_reset;

   always_ff @(posedge mclk) begin
      if (rst)
         inv_reset_reg <= `OTS_FLAG_RST;
      else
         inv_reset_reg <= fault_in.inv_reset;
   end

   // A trip arriving with the reset still wins, so it is never lost
   always_ff @(posedge mclk) begin
      if (rst)
         primary_fault_reg <= `OTS_FLAG_RST;
      else if (fault_in.trip)
         primary_fault_reg <= 1'b1; // RL4
      else if (fault_in.inv_reset || fault_in.power_off)
         primary_fault_reg <= 1'b0; // RL4
   end

   // Held through the whole reset, dropped on its release or on supply removal
   always_ff @(posedge mclk) begin
      if (rst)
         secondary_fault_reg <= `OTS_FLAG_RST;
      else if (fault_in.power_off)
         secondary_fault_reg <= 1'b0; // RL5
      else if (fault_in.trip)
         secondary_fault_reg <= 1'b1; // RL3
      else if (inv_reset_release)
         secondary_fault_reg <= 1'b0; // RL3
   end

   always_ff @(posedge mclk) begin
      if (rst)
         power_off_fault_reg <= `OTS_FLAG_RST;
      else if (fault_in.trip && fault_in.internal_cause)
         power_off_fault_reg <= 1'b1; // RL11
      else if (fault_in.inv_reset || fault_in.power_off)
         power_off_fault_reg <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Energy pulse train
   // ------------------------------------------------------------------
   logic [ENERGY_W:0]   energy_acc_reg;
   logic [ENERGY_W:0]   energy_sum;
   logic [ENERGY_W:0]   energy_step_ext;
   logic                energy_pulse_reg;

   // At most one pulse per valid; a surplus above the step carries over
   assign energy_sum      = energy_acc_reg + {1'b0, energy_inc};
   assign energy_step_ext = {1'b0, energy_step};

   always_ff @(posedge mclk) begin
      if (rst) begin
         energy_acc_reg   <= '0;
         energy_pulse_reg <= `OTS_FLAG_RST;
      end else begin
         energy_pulse_reg <= 1'b0;
         // A zero step would pulse without end; hold off instead
         if (energy_valid && energy_step != '0) begin
            if (energy_sum >= energy_step_ext) begin
               energy_acc_reg   <= energy_sum - energy_step_ext; // RL8
               energy_pulse_reg <= 1'b1; // RL8
            end else begin
               energy_acc_reg   <= energy_sum;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Energy-saving average update toggle
   // ------------------------------------------------------------------
   logic energy_avg_toggle_reg;

   always_ff @(posedge mclk) begin
      if (rst)
         energy_avg_toggle_reg <= `OTS_FLAG_RST;
      else if (energy_avg_update)
         energy_avg_toggle_reg <= ~energy_avg_toggle_reg; // RL6
   end

   // ------------------------------------------------------------------
   // Level conditions, taken straight to the terminals
   // ------------------------------------------------------------------
   logic dc_feeding;
   logic life_alarm;
   logic light_alarm;

   assign dc_feeding  = health.ac_power_fail | health.ac_undervoltage; // RL9
   assign life_alarm  = |health.life_worn; // RL10
   assign light_alarm = health.fan_fail | health.comm_warn; // RL12

   // Registered copies only for the monitor ports
   always_ff @(posedge mclk) begin
      if (rst) begin
         dc_feeding_out        <= `OTS_FLAG_RST;
         life_alarm_out        <= `OTS_FLAG_RST;
         light_alarm_out       <= `OTS_FLAG_RST;
         current_avg_pulse_out <= `OTS_FLAG_RST;
      end else begin
         dc_feeding_out        <= dc_feeding;
         life_alarm_out        <= life_alarm;
         light_alarm_out       <= light_alarm;
         current_avg_pulse_out <= current_avg_pulse_in;
      end
   end

   assign primary_fault_out     = primary_fault_reg;
   assign secondary_fault_out   = secondary_fault_reg;
   assign power_off_fault_out   = power_off_fault_reg;
   assign energy_pulse_out      = energy_pulse_reg;
   assign energy_avg_toggle_out = energy_avg_toggle_reg;

   // ------------------------------------------------------------------
   // Source vector, indexed by function code
   // ------------------------------------------------------------------
   logic [`OTS_NUM_FUNCS-1:0] src;

   always_comb begin
      src = gen_status;
      for (int i = 0; i < 4; i++) begin
         src[`OTS_F_MAINS1 + i] = pump.mains[i];
         src[`OTS_F_DRIVE1 + i] = pump.drive[i];
      end
      src[`OTS_F_ENERGY_PULSE] = energy_pulse_reg; // RL8
      src[`OTS_F_DC_FEED]      = dc_feeding; // RL9
      src[`OTS_F_LIFE]         = life_alarm; // RL10
      src[`OTS_F_PWR_OFF]      = power_off_fault_reg; // RL11
      src[`OTS_F_AVG_TOGGLE]   = energy_avg_toggle_reg; // RL6
      src[`OTS_F_CUR_AVG]      = current_avg_pulse_in; // RL7
      src[`OTS_F_FAULT2]       = secondary_fault_reg; // RL3
      src[`OTS_F_HOST_SET]     = 1'b0;
      src[`OTS_F_LIGHT]        = light_alarm; // RL12
      src[`OTS_F_FAULT]        = primary_fault_reg; // RL4
   end

   // ------------------------------------------------------------------
   // Fault code override
   // ------------------------------------------------------------------
   // Only the four status terminals carry the code; running and relays keep theirs
   assign fault_code_active = (fault_code_option == `OTS_FCODE_ON) & primary_fault_reg; // RL15

   // ------------------------------------------------------------------
   // Terminals
   // ------------------------------------------------------------------
   // Every terminal reads the same source vector, so one code may be
   // chosen on several terminals without interference.
   for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
      localparam bit RELAY = (t >= FIRST_RELAY);
      localparam bit FC_T  = (t >= `OTS_T_AT_SPEED) && (t <= `OTS_T_FREQ_DET);
      logic override_en;
      logic override_val;

      if (FC_T) begin : g_fc
         assign override_en  = fault_code_active; // RL15
         assign override_val = fault_code[t - `OTS_T_AT_SPEED];
      end else begin : g_nofc
         assign override_en  = 1'b0; // RL16
         assign override_val = 1'b0;
      end

      ots_terminal #(
         .IS_RELAY     (RELAY)
      ) u_term (
         .mclk         (mclk),
         .rst          (rst),
         .sel_code     (sel_code[t]),
         .src          (src),
         .host_bit     (host_set_output[t]),
         .override_en  (override_en),
         .override_val (override_val),
         .term_on      (terminal_on[t])
      ); // RL2 RL18
   end

endmodule
`default_nettype wire

// ---- test/ots_checker.sv ----
// Port assertions for the output terminal selector
`timescale 1ns/1ps
`default_nettype none
`include "ots_map.svh"
module ots_checker #(
   parameter int NUM_TERMS   = 7,
   parameter int FIRST_RELAY = 5
) (
   input wire logic                               mclk,
   input wire logic                               rst,
   input wire ots_pkg::ots_code_t [NUM_TERMS-1:0] sel_code,
   input wire logic [`OTS_NUM_FUNCS-1:0]          gen_status,
   input wire ots_pkg::ots_fault_in_s             fault_in,
   input wire logic [3:0]                         fault_code,
   input wire ots_pkg::ots_health_s               health,
   input wire logic                               energy_avg_update,
   input wire logic [NUM_TERMS-1:0]               terminal_on,
   input wire logic                               primary_fault_out,
   input wire logic                               secondary_fault_out,
   input wire logic                               power_off_fault_out,
   input wire logic                               energy_avg_toggle_out,
   input wire logic                               dc_feeding_out,
   input wire logic                               life_alarm_out,
   input wire logic                               light_alarm_out,
   input wire logic                               fault_code_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   dc_feed_a: assert property (1 |=> dc_feeding_out == $past(health.ac_power_fail | health.ac_undervoltage))
      else $error("dc feeding flag wrong");
   life_set_a: assert property (|health.life_worn |=> life_alarm_out)
      else $error("life alarm missing");
   light_set_a: assert property (health.fan_fail || health.comm_warn |=> light_alarm_out)
      else $error("light alarm missing");
   trip_set_a: assert property (fault_in.trip |=> primary_fault_out)
      else $error("primary fault not set");
   cause_set_a: assert property (fault_in.trip && fault_in.internal_cause |=> power_off_fault_out)
      else $error("power-off fault not set");
   sec_hold_a: assert property (secondary_fault_out && fault_in.inv_reset && !fault_in.power_off |=> secondary_fault_out)
      else $error("secondary fault dropped in reset");
   supply_drop_a: assert property (fault_in.power_off |=> !secondary_fault_out)
      else $error("secondary fault held without supply");
   prim_clear_a: assert property ((fault_in.inv_reset || fault_in.power_off) && !fault_in.trip
      |=> !primary_fault_out && !power_off_fault_out)
      else $error("primary fault not cleared");
   avg_flip_a: assert property (1 |=> energy_avg_toggle_out == ($past(energy_avg_toggle_out) ^ $past(energy_avg_update)))
      else $error("average toggle wrong");
   relay_refuse_a: assert property (sel_code[FIRST_RELAY] inside {8'h5C, 8'h5D, 8'hC0, 8'hC1}
      |=> !terminal_on[FIRST_RELAY])
      else $error("refused code drives relay");
   code_route_a: assert property (fault_code_active |=> terminal_on[1] == $past(fault_code[0]))
      else $error("fault code not routed");
   run_keep_a: assert property (sel_code[0] < 8'h40 |=> terminal_on[0] == $past(gen_status[sel_code[0]]))
      else $error("run terminal wrong");
   relay_neg_a: assert property (sel_code[NUM_TERMS-1] inside {[8'h64:8'hA3]}
      |=> terminal_on[NUM_TERMS-1] != $past(gen_status[sel_code[NUM_TERMS-1] - 8'h64]))
      else $error("negative relay wrong");
   cover property (fault_code_active);
   cover property (secondary_fault_out && fault_in.inv_reset);
   cover property (energy_avg_toggle_out);
endmodule
`default_nettype wire

// ---- test/ots_load.sv ----
// Equipment on the terminals: counts relay contact operations
`timescale 1ns/1ps
`default_nettype none
module ots_load #(
   parameter int NUM_TERMS   = 7,
   parameter int FIRST_RELAY = 5
) (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic [NUM_TERMS-1:0] terminal_on,
   output logic [15:0]               relay_ops
);
   logic [NUM_TERMS-1:0] seen_reg;
   logic [15:0]          ops_reg;
   assign relay_ops = ops_reg;
   // Every contact flip wears the relay, so the count must stay low
   always_ff @(posedge mclk) begin
      seen_reg <= terminal_on;
      if (rst) begin
         ops_reg <= 16'h0000;
      end else begin
         ops_reg <= ops_reg + 16'($countones((seen_reg ^ terminal_on) >> FIRST_RELAY));
      end
   end
endmodule
`default_nettype wire

// ---- test/output_terminal_function_select_test.sv ----
// Directed bench for the output terminal selector
`timescale 1ns/1ps
`default_nettype none
module output_terminal_function_select_test;
   logic                    mclk = 1'b0;
   logic                    rst = 1'b1;
   ots_pkg::ots_code_t [6:0] sel_code;
   ots_pkg::ots_code_t      fault_code_option;
   logic [6:0]              host_set_output, terminal_on;
   logic [99:0]             gen_status;
   ots_pkg::ots_fault_in_s  fault_in;
   logic [3:0]              fault_code;
   ots_pkg::ots_health_s    health;
   ots_pkg::ots_pump_s      pump;
   logic                    energy_valid, energy_avg_update, current_avg_pulse_in;
   logic [15:0]             energy_inc, energy_step, relay_ops;
   logic                    primary_fault_out, secondary_fault_out, power_off_fault_out, energy_pulse_out;
   logic                    energy_avg_toggle_out, dc_feeding_out, life_alarm_out, light_alarm_out;
   logic                    current_avg_pulse_out, fault_code_active;
   int                      n_fail = 0;
   int                      tests_run = 0;
   ots_top ots_top_inst (.mclk, .rst, .sel_code, .fault_code_option, .host_set_output, .gen_status,
      .fault_in, .fault_code, .health, .pump, .energy_valid, .energy_inc, .energy_step,
      .energy_avg_update, .current_avg_pulse_in, .terminal_on, .primary_fault_out,
      .secondary_fault_out, .power_off_fault_out, .energy_pulse_out, .energy_avg_toggle_out,
      .dc_feeding_out, .life_alarm_out, .light_alarm_out, .current_avg_pulse_out, .fault_code_active);
   ots_load ots_load_inst (.mclk, .rst, .terminal_on, .relay_ops);
   initial begin
      forever #50 mclk = ~mclk;
   end
   task automatic st(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic ev(input logic [15:0] inc, input logic p);
      energy_valid = 1'b1;
      energy_inc = inc;
      st(1);
      chk("energy pulse", 16'(p), 16'(energy_pulse_out));
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Tests take about 60 cycles; this is over sixty times that
   initial begin
      #400000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      sel_code = '0;
      fault_code_option = 8'h00;
      host_set_output = 7'h00;
      gen_status = '0;
      fault_in = '0;
      fault_code = 4'h0;
      health = '0;
      pump = '0;
      energy_valid = 1'b0;
      energy_inc = 16'h0000;
      energy_step = 16'h0000;
      energy_avg_update = 1'b0;
      current_avg_pulse_in = 1'b0;
      st(10);
      chk("reset terms", 16'h0000, 16'(terminal_on));
      rst = 1'b0;
      foreach (sel_code[t]) sel_code[t] = 8'h0C;
      gen_status[12] = 1'b1;
      st(1);
      chk("shared pos", 16'h007F, 16'(terminal_on));
      foreach (sel_code[t]) sel_code[t] = 8'h70;
      st(1);
      chk("shared neg", 16'h0000, 16'(terminal_on));
      gen_status[12] = 1'b0;
      st(1);
      chk("neg idle", 16'h007F, 16'(terminal_on));
      $display("test polarity done");
      sel_code[1] = 8'h55;
      sel_code[2] = 8'h5A;
      sel_code[3] = 8'h62;
      sel_code[4] = 8'hB9;
      for (int i = 0; i < 8; i++) begin
         health = ots_pkg::ots_health_s'(8'h01 << i);
         st(1);
         chk("health flags", 16'({i > 5, i inside {[2:5]}, i < 2}),
             16'({dc_feeding_out, life_alarm_out, light_alarm_out}));
         chk("health terms", 16'({i < 6, i < 2, i inside {[2:5]}, i > 5}), 16'(terminal_on[4:1]));
      end
      health = '0;
      $display("test health done");
      sel_code[6] = 8'hC8;
      for (int i = 0; i < 8; i++) begin
         sel_code[0] = 8'h47 + 8'(i);
         sel_code[5] = 8'hAB + 8'(i);
         pump = ots_pkg::ots_pump_s'(8'h01 << (i < 4 ? i + 4 : i - 4));
         st(1);
         chk("pump on", 16'h0001, 16'({terminal_on[5], terminal_on[0]}));
         pump = '0;
         st(1);
         chk("pump off", 16'h0000, 16'({terminal_on[6], terminal_on[5], terminal_on[0]}));
      end
      $display("test pump done");
      foreach (sel_code[t]) sel_code[t] = 8'h60;
      host_set_output = 7'h55;
      st(1);
      chk("host pos", 16'h0055, 16'(terminal_on));
      foreach (sel_code[t]) sel_code[t] = 8'hC4;
      fault_in = 4'h2;
      st(1);
      chk("host neg", 16'h002A, 16'(terminal_on));
      fault_in = '0;
      $display("test host done");
      sel_code[3] = 8'hC1;
      sel_code[4] = 8'h5C;
      sel_code[5] = 8'h5C;
      sel_code[6] = 8'hC1;
      energy_avg_update = 1'b1;
      st(1);
      energy_avg_update = 1'b0;
      chk("avg toggle", 16'h0001, 16'(energy_avg_toggle_out));
      st(1);
      chk("avg terms", 16'h0003, 16'(terminal_on[6:3]));
      current_avg_pulse_in = 1'b1;
      st(1);
      chk("cur avg out", 16'h0001, 16'(current_avg_pulse_out));
      chk("cur avg terms", 16'h0002, 16'(terminal_on[6:3]));
      current_avg_pulse_in = 1'b0;
      $display("test relay refusal done");
      energy_step = 16'h000A;
      ev(16'h0006, 1'b0);
      ev(16'h0006, 1'b1);
      ev(16'h0019, 1'b1);
      ev(16'h0000, 1'b1);
      ev(16'h0000, 1'b0);
      energy_step = 16'h0000;
      ev(16'h0032, 1'b0);
      energy_valid = 1'b0;
      $display("test energy done");
      sel_code[1] = 8'h5E;
      sel_code[2] = 8'hC7;
      sel_code[3] = 8'h5B;
      fault_in = 4'hC;
      st(1);
      fault_in = 4'h0;
      chk("trip flags", 16'h0007, 16'({primary_fault_out, secondary_fault_out, power_off_fault_out}));
      st(1);
      chk("trip terms", 16'h0005, 16'(terminal_on[3:1]));
      fault_in = 4'h2;
      st(2);
      chk("in reset", 16'h0002, 16'({primary_fault_out, secondary_fault_out, power_off_fault_out}));
      fault_in = 4'h0;
      st(1);
      chk("released", 16'h0000, 16'({primary_fault_out, secondary_fault_out, power_off_fault_out}));
      fault_in = 4'h8;
      st(1);
      chk("plain trip", 16'h0006, 16'({primary_fault_out, secondary_fault_out, power_off_fault_out}));
      fault_in = 4'h1;
      st(1);
      chk("supply off", 16'h0000, 16'({primary_fault_out, secondary_fault_out, power_off_fault_out}));
      fault_in = 4'h0;
      $display("test faults done");
      foreach (sel_code[t]) sel_code[t] = 8'h0C;
      gen_status[12] = 1'b1;
      fault_code_option = 8'h02;
      fault_code = 4'hA;
      fault_in = 4'h8;
      st(1);
      fault_in = 4'h0;
      st(1);
      chk("other option", 16'h007F, 16'(terminal_on));
      fault_code_option = 8'h01;
      st(1);
      chk("code active", 16'h0001, 16'(fault_code_active));
      chk("code terms", 16'h0075, 16'(terminal_on));
      fault_in = 4'h2;
      st(1);
      fault_in = 4'h0;
      st(1);
      chk("code released", 16'h007F, 16'(terminal_on));
      chk("relay wear", 16'h0001, 16'(relay_ops < 16'h0020));
      $display("test fault code done");
      report_and_stop;
   end
endmodule
bind ots_top ots_checker #(.NUM_TERMS(NUM_TERMS), .FIRST_RELAY(FIRST_RELAY)) ots_checker_inst (.mclk, .rst,
   .sel_code, .gen_status, .fault_in, .fault_code, .health, .energy_avg_update, .terminal_on, .primary_fault_out,
   .secondary_fault_out, .power_off_fault_out, .energy_avg_toggle_out, .dc_feeding_out, .life_alarm_out,
   .light_alarm_out, .fault_code_active);
`default_nettype wire
